// File: vdst_regs.vh
// Purpose: constants for the voltage id step tracker
// Assumes: 100 MHz core clock, switching cycle set by a cycle count
// Notes:   switching period default 2000 ns (500 kHz)
`ifndef VDST_REGS_VH
`define VDST_REGS_VH
`define VDST_CODE_W        8
`define VDST_CLK_PERIOD_NS 10
`define VDST_SW_PERIOD_NS  2000
`define VDST_SW_CYCLES     (`VDST_SW_PERIOD_NS / `VDST_CLK_PERIOD_NS)
`define VDST_SAMPLES       6
`define VDST_SAMPLE_CYCLES (`VDST_SW_CYCLES / `VDST_SAMPLES)
`define VDST_HALF_CYCLES   (`VDST_SW_CYCLES / 2)
`define VDST_CNT_W         12
`define VDST_BOOT_CODE     8'h4d
`define VDST_OFF_CODE_A    8'h00
`define VDST_OFF_CODE_B    8'hff
`define VDST_REF_MIN_UV    20'd12500
`define VDST_STEP_UV       21'd6250
`define VDST_TOP_UV        21'd1612500
`endif

// File: vdst_decode.v
// Purpose: linear decode of the code to a reference level in microvolts
// Assumes: one 6.25 mV step per code, higher code is lower level
// Notes:   registered output
`timescale 1ns/1ps
`include "vdst_regs.vh"
module vdst_decode (
    // Clock and reset
    input  wire        clk_in,
    input  wire        arst_n_in,
    // Code and level
    input  wire [7:0]  code_in,
    output reg  [20:0] level_uv_out
);
    // Level equals top minus code times step
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            level_uv_out <= 21'h000000;
        end else begin
            level_uv_out <= `VDST_TOP_UV - `VDST_STEP_UV * {13'h0000, code_in};
        end
    end
endmodule

// File: vdst_tracker.v
// Purpose: voltage id sampling and single-step reference tracking
// Assumes: code pins asynchronous to clk_in; enable_in already qualified
// Notes:   reference stored as a code, decoded to microvolts
// Function
// - The code decodes linearly, each code increment lowering the level by 6.25 mV.
// - The code pins are sampled six times per switching cycle while regulating.
// - After a changed code is seen, wait half a cycle then step once toward it.
// - If the difference to the reference differs at a sample strobe during the wait, the step is dropped.
// - When more than one step apart, step at each of the six samples until equal.
// - An off code read at the end of the boot hold shuts down until re-enabled.
`timescale 1ns/1ps
`include "vdst_regs.vh"
module vdst_tracker (
    // Clock and reset
    input  wire        clk_in,
    input  wire        arst_n_in,
    // Control
    input  wire        enable_in,
    input  wire        boot_done_in,
    // Code pins
    input  wire [7:0]  voltage_id_code_in,
    // Status and reference
    output reg  [7:0]  ref_code_out,
    output wire [20:0] ref_level_uv_out,
    output reg         regulating_out,
    output reg         shutdown_out,
    output wire        step_pulse_out
);
    localparam ST_IDLE = 2'd0;
    localparam ST_BOOT = 2'd1;
    localparam ST_RUN  = 2'd2;
    localparam ST_OFF  = 2'd3;

    // Counter reloads, cut to the counter width on purpose
    localparam [11:0] SAMPLE_RELOAD = `VDST_SAMPLE_CYCLES - 1;
    localparam [11:0] HALF_RELOAD   = `VDST_HALF_CYCLES - 1;

    // Timing overview
    // The switching cycle is a fixed count of core clocks.
    // One sixth of it gives the sample strobe period.
    // Half of it gives the wait before a single step.
    // Integer division drops a few clocks per cycle.
    // That error is far below one sample period.
    //
    // Code path
    // Code pins pass two flops before any compare.
    // A pin word may be caught mid-change by the flops.
    // Such a torn word looks like a changed code.
    // It is then caught again at the next sample.
    // A torn word during the wait cancels the step.
    // This is the intended safe outcome.
    //
    // Stepping
    // A fresh code arms the half-cycle wait.
    // The wait ends in one step toward the request.
    // Further steps happen only at sample strobes.
    // So a far target is reached at sample pace.
    // The step never runs past the request.
    // A request equal to the reference gives no step.
    //
    // Cancel
    // The code minus reference difference is kept.
    // A different difference at a strobe drops the step.
    // The new code then becomes the request.
    // Later strobes step toward it without a wait.
    //
    // Boot and off
    // The reference rests at the boot code until run.
    // The code is read once when the boot hold ends.
    // An off code freezes the reference for good.
    // Only dropping enable or reset leaves off.
    //
    // Limitations
    // No slew limit beyond the sample pace.
    // No filtering of codes that bounce at the pins.
    // The level output lags the code by one clock.

    reg  [7:0]  sync1_q, sync2_q;
    reg  [1:0]  state_q;
    reg  [11:0] samp_cnt_q;
    reg  [11:0] wait_cnt_q;
    reg         waiting_q;
    reg  [7:0]  req_q;
    reg  [8:0]  diff_q;
    reg         step_q;
    reg  [2:0]  en_sync_q;
    wire        sample_tick;
    wire [8:0]  diff_now;
    wire        is_off;

    assign sample_tick = (samp_cnt_q == 12'h000);
    assign diff_now    = {1'b0, sync2_q} - {1'b0, ref_code_out};
    assign is_off      = (sync2_q == `VDST_OFF_CODE_A) || (sync2_q == `VDST_OFF_CODE_B);
    assign step_pulse_out = step_q;

    // Two-stage code synchroniser; enable synchronised through three flops as it comes from a pin
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_q   <= 8'h00;
            sync2_q   <= 8'h00;
            en_sync_q <= 3'h0;
        end else begin
            sync1_q   <= voltage_id_code_in;
            sync2_q   <= sync1_q;
            en_sync_q <= {en_sync_q[1:0], enable_in};
        end
    end

    // Sample strobe, six per switching cycle
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            samp_cnt_q <= 12'h000;
        end else if (sample_tick) begin
            samp_cnt_q <= SAMPLE_RELOAD;
        end else begin
            samp_cnt_q <= samp_cnt_q - 12'h001;
        end
    end

    // Mode control; off state only left by dropping enable or by reset
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_IDLE;
        end else if (!en_sync_q[2]) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: state_q <= ST_BOOT;
                ST_BOOT: begin
                    if (boot_done_in) begin
                        state_q <= is_off ? ST_OFF : ST_RUN;
                    end
                end
                ST_RUN:  state_q <= ST_RUN;
                ST_OFF:  state_q <= ST_OFF;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Change detect, half-cycle wait, then one step
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ref_code_out   <= `VDST_BOOT_CODE;
            req_q          <= `VDST_BOOT_CODE;
            diff_q         <= 9'h000;
            waiting_q      <= 1'b0;
            wait_cnt_q     <= 12'h000;
            step_q         <= 1'b0;
            regulating_out <= 1'b0;
            shutdown_out   <= 1'b0;
        end else begin
            step_q         <= 1'b0;
            regulating_out <= (state_q == ST_RUN);
            shutdown_out   <= (state_q == ST_OFF);
            if (state_q != ST_RUN) begin
                waiting_q <= 1'b0;
                if (state_q != ST_OFF) begin
                    ref_code_out <= `VDST_BOOT_CODE;
                    req_q        <= `VDST_BOOT_CODE;
                end
            end else if (waiting_q) begin
                if (sample_tick && diff_now != diff_q) begin
                    waiting_q <= 1'b0;
                    req_q     <= sync2_q;
                end else if (wait_cnt_q == 12'h000) begin
                    waiting_q <= 1'b0;
                    // Code may have come back to the reference: no step then
                    if (req_q != ref_code_out) begin
                        step_q <= 1'b1;
                        // One code toward request, never past
                        if (req_q > ref_code_out) begin
                            ref_code_out <= ref_code_out + 8'h01;
                        end else begin
                            ref_code_out <= ref_code_out - 8'h01;
                        end
                    end
                end else begin
                    wait_cnt_q <= wait_cnt_q - 12'h001;
                end
            end else if (sample_tick) begin
                if (sync2_q != req_q) begin
                    // New code seen: start the half-cycle wait
                    req_q      <= sync2_q;
                    diff_q     <= diff_now;
                    waiting_q  <= 1'b1;
                    wait_cnt_q <= HALF_RELOAD;
                end else if (req_q != ref_code_out) begin
                    // Still apart: one step per sample
                    step_q <= 1'b1;
                    if (req_q > ref_code_out) begin
                        ref_code_out <= ref_code_out + 8'h01;
                    end else begin
                        ref_code_out <= ref_code_out - 8'h01;
                    end
                end
            end
        end
    end

    // Decoded level
    vdst_decode u_decode (
        .clk_in       (clk_in),
        .arst_n_in    (arst_n_in),
        .code_in      (ref_code_out),
        .level_uv_out (ref_level_uv_out)
    );
endmodule

// File: vdst_cpu_model.sv
// Purpose: processor driving the code pins
// Assumes: bench sets target and jump
// Notes:   paced single steps unless jump asked
`timescale 1ns/1ps
module vdst_cpu_model #(parameter PACE = 300) (
    // Clock and command
    input  wire       clk_in,
    input  wire [7:0] target_in,
    input  wire       jump_in,
    // Code pins
    output reg  [7:0] code_out
);
    integer cnt = 0;
    initial code_out = 8'h4d;
    // Slow pacing lets each step finish before the next code
    always @(posedge clk_in) begin
        cnt <= (cnt == PACE) ? 0 : cnt + 1;
        if (jump_in)
            code_out <= #1 target_in;
        else if (cnt == PACE && code_out != target_in)
            code_out <= #1 (code_out < target_in) ? code_out + 8'h01 : code_out - 8'h01;
    end
endmodule

// File: vdst_tracker_sva.sv
// Purpose: port checks for the tracker
// Assumes: reference moves at the pulse edge
// Notes:   level checked only while regulating
`timescale 1ns/1ps
module vdst_tracker_sva (
    input wire        clk_in,
    input wire        arst_n_in,
    input wire        enable_in,
    input wire [7:0]  ref_code_out,
    input wire [20:0] ref_level_uv_out,
    input wire        regulating_out,
    input wire        shutdown_out,
    input wire        step_pulse_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    chk_level_decode: assert property (regulating_out && $past(regulating_out) |->
        ref_level_uv_out == 21'd1612500 - 21'd6250 * $past(ref_code_out)) else $error("level");
    chk_idle_quiet: assert property (!regulating_out |-> !step_pulse_out)
        else $error("step idle");
    chk_step_gap: assert property (step_pulse_out |=> !step_pulse_out [*8])
        else $error("gap");
    chk_step_one: assert property (step_pulse_out |->
        (ref_code_out - $past(ref_code_out) == 8'h01) || ($past(ref_code_out) - ref_code_out == 8'h01))
        else $error("step size");
    chk_move_pulse: assert property ($past(regulating_out) && $changed(ref_code_out) |->
        step_pulse_out) else $error("silent move");
    chk_shut_off: assert property (shutdown_out |-> !regulating_out)
        else $error("shut run");
    chk_shut_hold: assert property (shutdown_out && enable_in |=> shutdown_out)
        else $error("shut left");
    chk_shut_still: assert property (shutdown_out |-> $stable(ref_code_out))
        else $error("shut move");
    cov_step: cover property (step_pulse_out);
    cov_shut: cover property ($rose(shutdown_out));
    cov_run: cover property ($rose(regulating_out));
endmodule
bind vdst_tracker vdst_tracker_sva chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .enable_in(enable_in), .ref_code_out(ref_code_out), .ref_level_uv_out(ref_level_uv_out),
    .regulating_out(regulating_out), .shutdown_out(shutdown_out),
    .step_pulse_out(step_pulse_out));

// File: test_vid_dac_step_tracker.sv
// Purpose: self-checking bench for the tracker
// Assumes: sample every 33 cycles, wait 100
// Notes:   expected codes from a bench model, expected levels as fixed values
`timescale 1ns/1ps
module test_vid_dac_step_tracker;
    reg         clk_in = 0, arst_n_in = 0, enable_in = 0, boot_done_in = 0, jump = 1;
    reg  [7:0]  target = 8'h4d;
    wire [7:0]  code, rc;
    wire [20:0] lv;
    wire        run, shut, pulse;
    integer     error_cnt = 0, num_checks = 0, i, t, pcnt = 0, r;
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) if (pulse) pcnt <= pcnt + 1;
    // Bench model of the reference: each pulse moves it one code toward the target
    integer     mref = 77;
    always @(negedge clk_in) begin
        if (!arst_n_in) mref = 77;
        else if (pulse) begin
            check(rc, (target > mref) ? mref + 1 : mref - 1);
            mref = rc;
        end
    end
    vdst_cpu_model cpu (.clk_in(clk_in), .target_in(target), .jump_in(jump), .code_out(code));
    vdst_tracker dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .enable_in(enable_in),
        .boot_done_in(boot_done_in), .voltage_id_code_in(code), .ref_code_out(rc),
        .ref_level_uv_out(lv), .regulating_out(run), .shutdown_out(shut), .step_pulse_out(pulse));
    task check(input [31:0] seen, input [31:0] exp); begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    end endtask
    task give_verdict; begin
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end endtask
    // Bounded wait for the reference to reach the target
    task settle(input integer lim); begin
        t = 0;
        while (rc !== target && t < lim) begin @(posedge clk_in); t = t + 1; end
        repeat (3) @(posedge clk_in); #1;
    end endtask
    task start(input [7:0] c); begin
        arst_n_in = 0; enable_in = 0; boot_done_in = 0; jump = 1; target = c;
        repeat (4) @(posedge clk_in); #1 check(rc, 8'h4d);
        arst_n_in = 1; enable_in = 1;
        repeat (8) @(posedge clk_in); #1 boot_done_in = 1;
    end endtask
    initial begin #600000; error_cnt = error_cnt + 1; give_verdict; end
    initial begin
        r = $urandom(32'hae6e);
        start(8'h80); repeat (300) @(posedge clk_in); #1 jump = 0; settle(4000);
        check(rc, 8'h80);
        check(lv, 812500);
        // Jump of fifteen codes must finish at sample pace
        jump = 1; target = 8'h8f; settle(700);
        check(lv, 718750);
        $display("test decode and jump done");
        jump = 0;
        for (i = 0; i < 4; i = i + 1) begin
            target = 8'h80 + ($urandom % 16); settle(5400);
            check(rc, target);
        end
        $display("test paced steps done");
        // Change then revert inside the wait: no step
        r = pcnt; t = rc; jump = 1; target = rc + 8'h01;
        repeat (45) @(posedge clk_in); #1 target = t;
        repeat (300) @(posedge clk_in); #1 check(pcnt, r);
        check(rc, t);
        $display("test cancel done");
        start(8'h00); repeat (300) @(posedge clk_in); #1;
        check({shut, run}, 2'b10);
        $display("test off code done");
        give_verdict;
    end
endmodule
